//--- src/vc_cap_pkg.sv
// Constants for the virtual channel extended capability register bank
package vc_cap_pkg;
   localparam logic [11:0] OFS_HEADER     = 12'h148;
   localparam logic [11:0] OFS_PORT_CAP1  = 12'h14C;
   localparam logic [11:0] OFS_PORT_CAP2  = 12'h150;
   localparam logic [11:0] OFS_PORT_STCTL = 12'h154;
   localparam logic [11:0] OFS_VC0_CAP    = 12'h158;
   localparam logic [11:0] OFS_VC0_CTRL   = 12'h15C;
   localparam logic [11:0] OFS_VC0_STAT   = 12'h160;

   localparam logic [15:0] CAP_ID_VC      = 16'h0002;
   localparam logic [3:0]  CAP_VERSION    = 4'h1;
   localparam logic [11:0] CAP_NEXT_PTR   = 12'h000;

   localparam logic [0:0]  EXT_VC_COUNT   = 1'h0;
   localparam logic [0:0]  LP_EXT_VC_CNT  = 1'h0;
   localparam logic [1:0]  REF_CLOCKS     = 2'h0;
   localparam logic [1:0]  PAT_ENTRY_SIZE = 2'h0;
   localparam logic [1:0]  VC_ARB_CAP     = 2'h0;
   localparam logic [7:0]  VC_ARB_TBL_OFS = 8'h00;
   localparam logic [0:0]  LOAD_ARB_TBL   = 1'h0;
   localparam logic [0:0]  ARB_SELECT     = 1'h0;
   localparam logic [0:0]  ARB_TBL_STATUS = 1'h0;

   localparam logic [7:0]  TC_MAP_RESET   = 8'hFF;
   localparam logic [0:0]  TC0_MAPPED     = 1'h1;
   localparam logic [0:0]  VC0_ENABLE     = 1'h1;
   localparam logic        PEND_RESET     = 1'b1;
   localparam int          TC_MAP_LSB     = 1;
   localparam int          TC_MAP_MSB     = 7;
   localparam int          VC0_EN_BIT     = 31;
   localparam int          VC0_PEND_BIT   = 17;
   localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;
endpackage

//--- src/vc_ext_capability_regs.sv
// APB register bank for the virtual channel extended capability structure
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps

// What this block does
// - The header's low sixteen bits always read the virtual channel capability ID 0002h.
// - The header's version field in bits 19:16 always reads one.
// - The header's next pointer in bits 31:20 reads zero, ending the capability chain.
// - Bit 0 of the first port capability reads zero, so only channel zero exists.
// - Bit 4 of the first port capability reads zero, no extra low-priority channels.
// - The reference clock field in bits 9:8 of the first port capability reads 00b.
// - The arbitration table entry size field in bits 11:10 reads zero.
// - The second port capability's arbitration capability and table offset read zero.
// - Port control bits 0 (load table) and 1 (arbitration select) read zero.
// - The arbitration table status bit 16 of the status and control word reads zero.
module vc_ext_capability_regs
   import vc_cap_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              vc0_negotiation_pending,
   output logic      [7:0]        tc_vc0_map
);

   // Offsets are twelve bits, so a narrower bus would alias the register map
   if (ADDR_W < $bits(OFS_HEADER)) begin : g_addr_w_check
      $error("ADDR_W must be at least 12");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;
   logic [7:0]  tc_map_r;
   logic        pend_r;

   wire  [11:0] word_addr = {paddr[11:2], 2'b00};
   wire         upper_ok  = (ADDR_W == 12) ? 1'b1 : (paddr[ADDR_W-1:0] >> 12) == '0;
   wire         aligned   = paddr[1:0] == 2'b00;
   // One comparator per register in map order; unaligned accesses miss them all
   localparam int          NUM_REGS = 7;
   localparam logic [11:0] REG_OFS [NUM_REGS] = '{OFS_HEADER, OFS_PORT_CAP1, OFS_PORT_CAP2,
                                                  OFS_PORT_STCTL, OFS_VC0_CAP, OFS_VC0_CTRL,
                                                  OFS_VC0_STAT};
   wire  [NUM_REGS-1:0] hit_vec;

   for (genvar g = 0; g < NUM_REGS; g++) begin : g_decode
      assign hit_vec[g] = upper_ok && aligned && word_addr == REG_OFS[g];
   end

   wire         hit_hdr   = hit_vec[0];
   wire         hit_cap1  = hit_vec[1];
   wire         hit_cap2  = hit_vec[2];
   wire         hit_stctl = hit_vec[3];
   wire         hit_vcap  = hit_vec[4];
   wire         hit_vctl  = hit_vec[5];
   wire         hit_vsts  = hit_vec[6];
   wire         hit_any   = |hit_vec;

   // One wait state: pready rises on the second access cycle
   wire         access    = psel && penable && !pready_r;
   wire         complete  = psel && penable && pready_r;
   wire         do_write  = complete && pwrite && hit_vctl && pstrb[0];

   ////////////////////////////////////////////////////////////////////////////
   // Read values, reserved bits tied low

   wire  [31:0] hdr_word   = {CAP_NEXT_PTR, CAP_VERSION, CAP_ID_VC};
   wire  [31:0] cap1_word  = {20'h00000, PAT_ENTRY_SIZE, REF_CLOCKS,
                              3'h0, LP_EXT_VC_CNT, 3'h0, EXT_VC_COUNT};
   wire  [31:0] cap2_word  = {VC_ARB_TBL_OFS, 22'h000000, VC_ARB_CAP};
   wire  [31:0] stctl_word = {15'h0000, ARB_TBL_STATUS,
                              14'h0000, ARB_SELECT, LOAD_ARB_TBL};
   wire  [31:0] vctl_word  = {VC0_ENABLE, 23'h000000, tc_map_r[TC_MAP_MSB:TC_MAP_LSB],
                              TC0_MAPPED};
   wire  [31:0] vsts_word  = {14'h0000, pend_r, 17'h00000};

   wire  [31:0] rd_mux = hit_hdr   ? hdr_word   :
                         hit_cap1  ? cap1_word  :
                         hit_cap2  ? cap2_word  :
                         hit_stctl ? stctl_word :
                         hit_vctl  ? vctl_word  :
                         hit_vsts  ? vsts_word  : ZERO_WORD;

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= ZERO_WORD;
      end else begin
         pready_r  <= access;
         pslverr_r <= access && !hit_any;
         prdata_r  <= (access && !pwrite) ? rd_mux : ZERO_WORD;
      end
   end

   // Only the traffic class map bits 7:1 accept writes; all else is dropped
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tc_map_r <= TC_MAP_RESET;
      end else if (do_write) begin
         tc_map_r <= {pwdata[TC_MAP_MSB:TC_MAP_LSB], TC0_MAPPED};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pend_r <= PEND_RESET;
      end else begin
         pend_r <= vc0_negotiation_pending;
      end
   end

   assign prdata     = prdata_r;
   assign pready     = pready_r;
   assign pslverr    = pslverr_r;
   assign tc_vc0_map = tc_map_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   wire rd_done = complete && !pwrite;

   property p_hdr_id;
      @(posedge clk) disable iff (!rst_n)
      rd_done && hit_hdr |-> prdata[15:0] == 16'h0002;
   endproperty
   a_hdr_id: assert property (p_hdr_id) else $error("capability id wrong");

   property p_hdr_ver;
      @(posedge clk) disable iff (!rst_n)
      access && !pwrite && hit_hdr |=> pready && prdata[19:16] == 4'h1;
   endproperty
   a_hdr_ver: assert property (p_hdr_ver) else $error("capability version wrong");

   property p_hdr_next;
      @(posedge clk) disable iff (!rst_n)
      rd_done && hit_hdr |-> prdata[31:20] == 12'h000 && !pslverr;
   endproperty
   a_hdr_next: assert property (p_hdr_next) else $error("next pointer not zero");

   property p_cap1_bits;
      @(posedge clk) disable iff (!rst_n)
      rd_done && hit_cap1 |-> prdata[0] == 1'b0 && prdata[4] == 1'b0;
   endproperty
   a_cap1_bits: assert property (p_cap1_bits) else $error("vc count bits set");

   property p_cap1_fields;
      @(posedge clk) disable iff (!rst_n)
      rd_done && hit_cap1 |-> prdata[11:8] == 4'h0 && prdata[31:12] == 20'h00000;
   endproperty
   a_cap1_fields: assert property (p_cap1_fields) else $error("cap1 fields set");

   property p_cap2;
      @(posedge clk) disable iff (!rst_n)
      rd_done && hit_cap2 |-> prdata == 32'h0000_0000;
   endproperty
   a_cap2: assert property (p_cap2) else $error("cap2 not zero");

   property p_ctl;
      @(posedge clk) disable iff (!rst_n)
      rd_done && hit_stctl |-> prdata[1:0] == 2'h0;
   endproperty
   a_ctl: assert property (p_ctl) else $error("port control bits set");

   property p_sts;
      @(posedge clk) disable iff (!rst_n)
      rd_done && hit_stctl |-> prdata[16] == 1'b0 && prdata[31:17] == 15'h0000;
   endproperty
   a_sts: assert property (p_sts) else $error("table status set");

   property p_wr_ignored;
      @(posedge clk) disable iff (!rst_n)
      complete && pwrite && !hit_vctl |=> $stable(tc_vc0_map);
   endproperty
   a_wr_ignored: assert property (p_wr_ignored) else $error("write to ro changed state");

   property p_tc0_kept;
      @(posedge clk) disable iff (!rst_n)
      do_write |=> tc_vc0_map[0] == 1'b1 && tc_vc0_map[7:1] == $past(pwdata[7:1]);
   endproperty
   a_tc0_kept: assert property (p_tc0_kept) else $error("tc map write wrong");

   property p_answer_next;
      @(posedge clk) disable iff (!rst_n)
      access |=> pready;
   endproperty
   a_answer_next: assert property (p_answer_next) else $error("no answer after one wait");

   property p_ready_pulse;
      @(posedge clk) disable iff (!rst_n)
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

   property p_ready_cause;
      @(posedge clk) disable iff (!rst_n)
      pready |-> $past(access);
   endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("ready without access");

   property p_err_with_ready;
      @(posedge clk) disable iff (!rst_n)
      pslverr |-> pready;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");

   property p_rdata_quiet;
      @(posedge clk) disable iff (!rst_n)
      !pready |-> prdata == ZERO_WORD;
   endproperty
   a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside answer");

   property p_wdata_quiet;
      @(posedge clk) disable iff (!rst_n)
      complete && pwrite |-> prdata == ZERO_WORD;
   endproperty
   a_wdata_quiet: assert property (p_wdata_quiet) else $error("read data on a write");

   property p_unmapped;
      @(posedge clk) disable iff (!rst_n)
      complete && !hit_any |-> pslverr && prdata == ZERO_WORD;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access answered");

   property p_mapped_ok;
      @(posedge clk) disable iff (!rst_n)
      complete && hit_any |-> !pslverr;
   endproperty
   a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access errored");

   property p_vcap_zero;
      @(posedge clk) disable iff (!rst_n)
      rd_done && hit_vcap |-> prdata == 32'h0000_0000;
   endproperty
   a_vcap_zero: assert property (p_vcap_zero) else $error("vc0 capability not zero");

   property p_cap1_rsvd;
      @(posedge clk) disable iff (!rst_n)
      rd_done && hit_cap1 |-> prdata[3:1] == 3'h0 && prdata[7:5] == 3'h0;
   endproperty
   a_cap1_rsvd: assert property (p_cap1_rsvd) else $error("cap1 reserved set");

   property p_stctl_rsvd;
      @(posedge clk) disable iff (!rst_n)
      rd_done && hit_stctl |-> prdata[15:2] == 14'h0000;
   endproperty
   a_stctl_rsvd: assert property (p_stctl_rsvd) else $error("control reserved set");

   property p_vctl_read;
      @(posedge clk) disable iff (!rst_n)
      rd_done && hit_vctl |-> prdata[VC0_EN_BIT] && prdata[VC0_EN_BIT-1:TC_MAP_MSB+1] == '0
                             && prdata[TC_MAP_MSB:0] == tc_vc0_map;
   endproperty
   a_vctl_read: assert property (p_vctl_read) else $error("vc0 control read wrong");

   property p_vsts_read;
      @(posedge clk) disable iff (!rst_n)
      rd_done && hit_vsts |-> prdata[VC0_PEND_BIT] == $past(pend_r)
                             && prdata[31:VC0_PEND_BIT+1] == '0
                             && prdata[VC0_PEND_BIT-1:0] == '0;
   endproperty
   a_vsts_read: assert property (p_vsts_read) else $error("vc0 status read wrong");

   property p_pend_follow;
      @(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> pend_r == $past(vc0_negotiation_pending);
   endproperty
   a_pend_follow: assert property (p_pend_follow) else $error("pending bit stale");

   property p_tc0_fixed;
      @(posedge clk) disable iff (!rst_n)
      tc_vc0_map[0] == TC0_MAPPED;
   endproperty
   a_tc0_fixed: assert property (p_tc0_fixed) else $error("tc0 unmapped");

   property p_strobe_off;
      @(posedge clk) disable iff (!rst_n)
      complete && pwrite && hit_vctl && !pstrb[0] |=> $stable(tc_vc0_map);
   endproperty
   a_strobe_off: assert property (p_strobe_off) else $error("unstrobed write landed");

   property p_map_hold;
      @(posedge clk) disable iff (!rst_n)
      rst_n && !do_write |=> $stable(tc_vc0_map);
   endproperty
   a_map_hold: assert property (p_map_hold) else $error("map changed without write");

   // Not disabled by reset, so that the reset branch itself is watched
   property p_reset_values;
      @(posedge clk)
      !rst_n |=> !pready && !pslverr && prdata == ZERO_WORD && tc_vc0_map == TC_MAP_RESET
                 && pend_r == PEND_RESET;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

   c_rd_hdr:   cover property (@(posedge clk) disable iff (!rst_n) rd_done && hit_hdr);
   c_wr_vctl:  cover property (@(posedge clk) disable iff (!rst_n) do_write);
   c_unmapped: cover property (@(posedge clk) disable iff (!rst_n) pready && pslverr);
   c_b2b:      cover property (@(posedge clk) disable iff (!rst_n)
                               complete ##1 (psel && !penable) ##1 access);
   c_rd_pend:  cover property (@(posedge clk) disable iff (!rst_n)
                               rd_done && hit_vsts && prdata[VC0_PEND_BIT]);

endmodule

//--- testbench/vc_ext_capability_regs_bench.sv
// Self-checking bench for the virtual channel capability register bank
`timescale 1ns/100ps
module vc_ext_capability_regs_bench;
   import vc_cap_pkg::*;
   logic        clk, rst_n, psel, penable, pwrite, pend, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rnd;
   logic [3:0]  pstrb;
   logic [7:0]  tc_vc0_map, map_exp;
   logic [33:0] notes[$];
   logic [33:0] nt;
   int          errors, tests_run;
   logic [11:0] ofs[7] = '{OFS_HEADER, OFS_PORT_CAP1, OFS_PORT_CAP2, OFS_PORT_STCTL,
                           OFS_VC0_CAP, OFS_VC0_CTRL, OFS_VC0_STAT};
   logic [11:0] bad[5] = '{12'h164, 12'h144, 12'h149, 12'h000, 12'hFFE};

   vc_ext_capability_regs dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .vc0_negotiation_pending(pend),
      .tc_vc0_map(tc_vc0_map));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected read value; bit fields fixed at zero unless stated
   function automatic logic [31:0] exp_of(input logic [11:0] a);
      case (a)
         OFS_HEADER:   return 32'h0001_0002;
         OFS_VC0_CTRL: return {24'h80_0000, map_exp};
         OFS_VC0_STAT: return {14'h0000, pend, 17'h0_0000};
         default:      return 32'h0000_0000;
      endcase
   endfunction

   task automatic check(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1) begin
         errors++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Leaves psel high so a following transfer can start its setup at once
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [33:0] e);
      int n;
      n = 0;
      notes.push_back(e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) check(1'b0, "no answer");
   endtask

   task automatic idle;
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Response monitor; note = {check data, error, data}
   always @(posedge clk) begin
      if (pready === 1'b1) begin
         if (notes.size() == 0) check(1'b0, "unexpected answer");
         else begin
            nt = notes.pop_front();
            check(pslverr === nt[32] && (!nt[33] || prdata === nt[31:0]), "bad response");
         end
      end
   end

   initial begin
      repeat (2000) @(posedge clk);
      errors++;
      final_report();
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'hF;
      pend = 1'b1;
      rst_n = 1'b0;
      rnd = 32'h0000_0015;
      map_exp = 8'hFF;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check(tc_vc0_map === 8'hFF, "map reset value");
      for (int i = 0; i < 7; i++) apb(1'b0, ofs[i], 32'h0, 4'hF, {2'b10, exp_of(ofs[i])});
      $display("test reset reads done");
      for (int r = 0; r < 3; r++) begin
         // Random data on every register; only the map byte may change
         for (int i = 0; i < 7; i++) begin
            rnd = lfsr(rnd);
            apb(1'b1, ofs[i], rnd, {rnd[3:1], r[0]}, 34'h0);
            if (ofs[i] == OFS_VC0_CTRL && r[0]) map_exp = rnd[7:0] | 8'h01;
         end
         pend <= rnd[31];
         idle();
         check(tc_vc0_map === map_exp, "map output");
         for (int i = 0; i < 7; i++) apb(1'b0, ofs[i], 32'h0, 4'hF, {2'b10, exp_of(ofs[i])});
         $display("test write round %0d done", r);
      end
      foreach (bad[i]) apb(i[0], bad[i], 32'hFFFF_FFFF, 4'hF, {2'b11, 32'h0});
      idle();
      check(tc_vc0_map === map_exp, "map after unmapped writes");
      $display("test unmapped done");
      // Second reset in mid-run must bring back the map; the pending bit then reads the driven input, zero
      rnd = lfsr(rnd);
      apb(1'b1, OFS_VC0_CTRL, rnd, 4'h1, 34'h0);
      idle();
      rst_n <= 1'b0;
      pend <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      map_exp = TC_MAP_RESET;
      @(posedge clk);
      check(tc_vc0_map === map_exp, "map after second reset");
      apb(1'b0, OFS_VC0_CTRL, 32'h0, 4'hF, {2'b10, exp_of(OFS_VC0_CTRL)});
      apb(1'b0, OFS_VC0_STAT, 32'h0, 4'hF, {2'b10, exp_of(OFS_VC0_STAT)});
      idle();
      $display("test second reset done");
      final_report();
   end
endmodule
